// >>> tpwm_pkg.sv
package tpwm_pkg;

	// Register bus geometry
	localparam int TPWM_ADDR_W = 8;
	localparam int TPWM_DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] TPWM_OFF_CONTROL = 8'h00;
	localparam logic [7:0] TPWM_OFF_STATUS = 8'h04;
	localparam logic [7:0] TPWM_OFF_PERIOD = 8'h08;
	localparam logic [7:0] TPWM_OFF_DEAD = 8'h0C;
	localparam logic [7:0] TPWM_OFF_DUTY0 = 8'h10;
	localparam logic [7:0] TPWM_OFF_DUTY1 = 8'h14;
	localparam logic [7:0] TPWM_OFF_DUTY2 = 8'h18;
	localparam logic [7:0] TPWM_OFF_OEC = 8'h1C;

	// Field widths
	localparam int TPWM_PERIOD_W = 16;
	localparam int TPWM_DEAD_W = 10;
	localparam int TPWM_DUTY_W = 16;
	localparam int TPWM_OEC_W = 9;
	localparam int TPWM_PAIRS = 3;

	// Field positions
	localparam int TPWM_CTRL_DOUBLE_BIT = 2;
	localparam int TPWM_STA_HALF_BIT = 0;
	localparam int TPWM_STA_TRIP_BIT = 3;
	localparam int TPWM_OEC_XOVER_TOP = 8;
	localparam int TPWM_OEC_DIS_TOP = 5;

	// Indices of the written-once flags
	localparam int TPWM_WR_PERIOD = 0;
	localparam int TPWM_WR_DUTY0 = 1;
	localparam int TPWM_WR_FLAGS = 4;

	// Reset values
	localparam logic TPWM_DOUBLE_RST = 1'b0;
	localparam logic [15:0] TPWM_PERIOD_RST = 16'h0000;
	localparam logic [9:0] TPWM_DEAD_RST = 10'h000;
	localparam logic [15:0] TPWM_DUTY_RST = 16'h0000;
	localparam logic [8:0] TPWM_OEC_RST = 9'h000;
	localparam logic [5:0] TPWM_OUT_OFF = 6'h3F;

	typedef struct packed {
		logic [TPWM_PERIOD_W-1:0] period;
		logic [TPWM_DEAD_W-1:0] dead;
		logic [TPWM_PAIRS-1:0][TPWM_DUTY_W-1:0] duty;
		logic [TPWM_OEC_W-1:0] oec;
	} tpwm_cfg_t;

	typedef struct packed {
		logic high_on;
		logic low_on;
	} tpwm_pair_t;

	typedef enum logic [1:0] {
		TPWM_FIRST = 2'b01,
		TPWM_SECOND = 2'b10
	} tpwm_half_t;

endpackage

// >>> tpwm_phase.sv
`timescale 1ns/1ns
module tpwm_phase #(
	parameter int CNT_W = 16,
	parameter int DEAD_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [CNT_W-1:0] cnt,
	input wire logic second_half,
	input wire logic [CNT_W-1:0] period,
	input wire logic [DEAD_W-1:0] dead,
	input wire logic [CNT_W-1:0] duty,
	output tpwm_pkg::tpwm_pair_t pair
);
	import tpwm_pkg::*;

	initial
	begin
		if (CNT_W < 2 || DEAD_W < 1 || DEAD_W > CNT_W)
			$error("tpwm_phase: unsupported width");
	end

	// Two spare bits keep every difference signed and overflow free
	wire logic signed [CNT_W+1:0] c = $signed({2'b00, cnt});
	wire logic signed [CNT_W+1:0] p = $signed({2'b00, period});
	wire logic signed [CNT_W+1:0] d = $signed({2'b00, duty});
	wire logic signed [CNT_W+1:0] t = $signed({{(CNT_W+2-DEAD_W){1'b0}}, dead});

	// Both edges move away from the duty instant by the dead time
	wire logic signed [CNT_W+1:0] hi_first_on = p - d + t;
	wire logic signed [CNT_W+1:0] lo_first_off = p - d - t;
	wire logic signed [CNT_W+1:0] hi_second_off = d - t;
	wire logic signed [CNT_W+1:0] lo_second_on = d + t;

	// Comparisons saturate naturally between 0% and 100%
	wire logic next_high = second_half ? (c < hi_second_off) : (c >= hi_first_on);
	wire logic next_low = second_half ? (c >= lo_second_on) : (c < lo_first_off);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pair <= '0;
		else
			pair <= '{high_on: next_high, low_on: next_low};
	end

endmodule // tpwm_phase

// >>> tpwm_timing.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - Two interrupt outputs: one per sync pulse, one per shutdown action.
// - Period register holds core cycles in half a switching period.
// - One 10-bit dead-time register serves all three output pairs.
// - Dead time is register value times two core cycles; zero gives none.
// - Control bit 2 selects double update; reset leaves single update.
// - Single mode: one sync per period, its edge loads all timing values.
// - Enable and crossover register is captured on the same sync edges.
// - Double mode adds a midpoint sync that loads all values again.
// - Status bit 0 is zero in the first half, one in the second.
// - Three 16-bit duty registers give high-side on-time per half period.
// - Timing outputs are active low; low turns the switch on.
// - Dead time moves both complementary edges equally from the duty instant.
// - Single mode on-times are 2(duty-dead) and 2(period-duty-dead), clamped.
// - Double mode halves use own values; on-times clamp within the period.
// - Channels one and two work exactly like channel zero.
// - No outputs until period and all three duties are written once.
// - A period register write starts the main period timer.
// - First sync comes 1.5 periods after the period write, one in double mode.
// - Each of the six outputs can be disabled on its own.
// - The trip input produces the reset that stops the timing unit.
// - Sync control makes the internal sync; the external pin is never chosen.
// - Trip low forces outputs off and blocks sync without clocked logic.
// - Bits 8,7,6 swap pairs 0,1,2; bits 0-5 hold outputs off; reset clears.
// - After shutdown, resume needs all four rewritten and trip high again.
module tpwm_timing (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tpwm_pkg::TPWM_ADDR_W-1:0] paddr,
	input wire logic [tpwm_pkg::TPWM_DATA_W-1:0] pwdata,
	output logic [tpwm_pkg::TPWM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fault_trip_input_n,
	output logic pair0_high_out_n,
	output logic pair0_low_out_n,
	output logic pair1_high_out_n,
	output logic pair1_low_out_n,
	output logic pair2_high_out_n,
	output logic pair2_low_out_n,
	output logic period_sync_pulse,
	output logic sync_irq,
	output logic trip_irq
);
	import tpwm_pkg::*;

	// Pin wiring and flag layout below are fixed to three pairs
	initial
	begin
		if (TPWM_PAIRS != 3 || TPWM_OEC_W != 9)
			$error("tpwm_timing: output stage serves three pairs only");
		if (TPWM_WR_FLAGS != TPWM_PAIRS + 1 || TPWM_WR_PERIOD != 0 || TPWM_WR_DUTY0 != 1)
			$error("tpwm_timing: written-once flag layout unsupported");
		if (TPWM_DEAD_W > TPWM_PERIOD_W)
			$error("tpwm_timing: dead time wider than the period");
	end

	// Register file
	logic double_mode;
	tpwm_cfg_t cfg;
	tpwm_cfg_t act;
	logic [TPWM_WR_FLAGS-1:0] written;

	// Timer state
	tpwm_half_t half;
	logic [TPWM_PERIOD_W-1:0] cnt;
	logic run;
	logic armed;

	// Trip synchroniser and edge detect
	logic trip_meta;
	logic trip_s;
	logic trip_prev;

	// Output stage
	tpwm_pair_t [TPWM_PAIRS-1:0] pair;
	logic [5:0] pwm_q;
	logic sync_q;

	// APB decode
	wire logic apb_setup_done = psel & penable & ~pready;
	wire logic apb_access = psel & penable & pready;
	wire logic apb_wr = apb_access & pwrite;
	wire logic hit_control = (paddr == TPWM_OFF_CONTROL);
	wire logic hit_status = (paddr == TPWM_OFF_STATUS);
	wire logic hit_period = (paddr == TPWM_OFF_PERIOD);
	wire logic hit_dead = (paddr == TPWM_OFF_DEAD);
	wire logic hit_duty0 = (paddr == TPWM_OFF_DUTY0);
	wire logic hit_duty1 = (paddr == TPWM_OFF_DUTY1);
	wire logic hit_duty2 = (paddr == TPWM_OFF_DUTY2);
	wire logic hit_oec = (paddr == TPWM_OFF_OEC);
	wire logic addr_known = hit_control | hit_status | hit_period | hit_dead |
		hit_duty0 | hit_duty1 | hit_duty2 | hit_oec;
	wire logic [TPWM_PAIRS-1:0] hit_duty = {hit_duty2, hit_duty1, hit_duty0};

	wire logic wr_period = apb_wr & hit_period;
	wire logic [TPWM_PAIRS-1:0] wr_duty = {TPWM_PAIRS{apb_wr}} & hit_duty;
	// Write marks laid out like the written-once flags
	wire logic [TPWM_WR_FLAGS-1:0] wr_mark;
	assign wr_mark[TPWM_WR_PERIOD] = wr_period;
	assign wr_mark[TPWM_WR_DUTY0 +: TPWM_PAIRS] = wr_duty;

	// Places one flag at its bit position in a bus word
	function automatic logic [TPWM_DATA_W-1:0] flag_word(input logic flag, input int pos);
		flag_word = '0;
		flag_word[pos] = flag;
	endfunction

	// Read multiplexer
	wire logic [TPWM_DATA_W-1:0] rd_control =
		flag_word(double_mode, TPWM_CTRL_DOUBLE_BIT);
	wire logic [TPWM_DATA_W-1:0] rd_status =
		flag_word(half == TPWM_SECOND, TPWM_STA_HALF_BIT) |
		flag_word(trip_s, TPWM_STA_TRIP_BIT);
	wire logic [TPWM_DATA_W-1:0] rd_mux =
		hit_control ? rd_control :
		hit_status ? rd_status :
		hit_period ? TPWM_DATA_W'(cfg.period) :
		hit_dead ? TPWM_DATA_W'(cfg.dead) :
		hit_duty0 ? TPWM_DATA_W'(cfg.duty[0]) :
		hit_duty1 ? TPWM_DATA_W'(cfg.duty[1]) :
		hit_duty2 ? TPWM_DATA_W'(cfg.duty[2]) :
		hit_oec ? TPWM_DATA_W'(cfg.oec) :
		'0;

	// Shutdown and timer sequencing
	wire logic trip_event = trip_prev & ~trip_s;
	wire logic all_written = &written;
	wire logic start = ~run & trip_s & written[TPWM_WR_PERIOD];
	wire logic half_end = run & (cnt == act.period - 16'h0001);
	// Period start always loads; midpoint loads only in double mode
	wire logic load_evt = half_end & ((half == TPWM_SECOND) | double_mode);
	// Internal sync is the only source; no external sync path exists
	wire logic sync_fire = load_evt & all_written & trip_s;
	// Single mode starts mid-half so the first sync lands 1.5 periods out
	wire logic [TPWM_PERIOD_W-1:0] start_cnt = double_mode ? '0 : (cfg.period >> 1);

	// APB slave: one wait state, then data and error from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= apb_setup_done;
			pslverr <= apb_setup_done & ~addr_known;
			if (apb_setup_done & ~pwrite)
				prdata <= rd_mux;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			double_mode <= TPWM_DOUBLE_RST;
			cfg.period <= TPWM_PERIOD_RST;
			cfg.dead <= TPWM_DEAD_RST;
			cfg.duty <= {TPWM_PAIRS{TPWM_DUTY_RST}};
			cfg.oec <= TPWM_OEC_RST;
		end
		else if (apb_wr)
		begin
			if (hit_control)
				double_mode <= pwdata[TPWM_CTRL_DOUBLE_BIT];
			if (hit_period)
				cfg.period <= pwdata[TPWM_PERIOD_W-1:0];
			if (hit_dead)
				cfg.dead <= pwdata[TPWM_DEAD_W-1:0];
			for (int i = 0; i < TPWM_PAIRS; i++)
				if (hit_duty[i])
					cfg.duty[i] <= pwdata[TPWM_DUTY_W-1:0];
			if (hit_oec)
				cfg.oec <= pwdata[TPWM_OEC_W-1:0];
		end
	end

	// Written-once flags; a write in the trip cycle still counts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			written <= '0;
		else
			written <= (trip_event ? '0 : written) | wr_mark;
	end

	// Trip pin synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip_meta <= 1'b0;
			trip_s <= 1'b0;
			trip_prev <= 1'b0;
		end
		else
		begin
			trip_meta <= fault_trip_input_n;
			trip_s <= trip_meta;
			trip_prev <= trip_s;
		end
	end

	// Main period timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run <= 1'b0;
			half <= TPWM_FIRST;
			cnt <= '0;
		end
		else if (trip_event | ~trip_s)
		begin
			run <= 1'b0;
			half <= TPWM_FIRST;
			cnt <= '0;
		end
		else if (start)
		begin
			run <= 1'b1;
			half <= TPWM_FIRST;
			cnt <= start_cnt;
		end
		else if (half_end)
		begin
			cnt <= '0;
			unique case (half)
				TPWM_FIRST: half <= TPWM_SECOND;
				TPWM_SECOND: half <= TPWM_FIRST;
			endcase
		end
		else if (run)
			cnt <= cnt + 16'h0001;
	end

	// Active timing values, loaded on sync edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act <= '0;
			armed <= 1'b0;
		end
		else if (trip_event)
			armed <= 1'b0;
		else if (start)
			act.period <= cfg.period;
		else if (load_evt)
		begin
			act <= cfg;
			armed <= armed | all_written;
		end
	end

	// Three identical phase generators
	for (genvar g = 0; g < TPWM_PAIRS; g++)
	begin : g_phase
		tpwm_phase #(
			.CNT_W(TPWM_PERIOD_W),
			.DEAD_W(TPWM_DEAD_W)
		) u_phase (
			.pclk(pclk),
			.presetn(presetn),
			.cnt(cnt),
			.second_half(half == TPWM_SECOND),
			.period(act.period),
			.dead(act.dead),
			.duty(act.duty[g]),
			.pair(pair[g])
		);
	end

	// Timing-unit commands as pin levels, before crossover and disable
	wire logic [TPWM_PAIRS-1:0] hi_n;
	wire logic [TPWM_PAIRS-1:0] lo_n;
	for (genvar g = 0; g < TPWM_PAIRS; g++)
	begin : g_level
		assign hi_n[g] = ~pair[g].high_on;
		assign lo_n[g] = ~pair[g].low_on;
	end

	// Crossover first, then per-output disable; result is active low
	logic [5:0] next_pwm;
	always_comb
	begin
		next_pwm = TPWM_OUT_OFF;
		for (int i = 0; i < TPWM_PAIRS; i++)
		begin
			if (act.oec[TPWM_OEC_XOVER_TOP-i])
			begin
				next_pwm[2*i] = lo_n[i];
				next_pwm[2*i+1] = hi_n[i];
			end
			else
			begin
				next_pwm[2*i] = hi_n[i];
				next_pwm[2*i+1] = lo_n[i];
			end
			// Disable bit pairs count down from bit 5: L then H per pair
			if (act.oec[TPWM_OEC_DIS_TOP-2*i-1])
				next_pwm[2*i] = 1'b1;
			if (act.oec[TPWM_OEC_DIS_TOP-2*i])
				next_pwm[2*i+1] = 1'b1;
		end
		if (!(run & armed & trip_s))
			next_pwm = TPWM_OUT_OFF;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_q <= TPWM_OUT_OFF;
			sync_q <= 1'b0;
			sync_irq <= 1'b0;
			trip_irq <= 1'b0;
		end
		else
		begin
			pwm_q <= next_pwm;
			sync_q <= sync_fire;
			sync_irq <= sync_fire;
			trip_irq <= trip_event;
		end
	end

	// Trip pin gates the pins directly so a dead clock cannot hold a switch on
	assign pair0_high_out_n = pwm_q[0] | ~fault_trip_input_n;
	assign pair0_low_out_n = pwm_q[1] | ~fault_trip_input_n;
	assign pair1_high_out_n = pwm_q[2] | ~fault_trip_input_n;
	assign pair1_low_out_n = pwm_q[3] | ~fault_trip_input_n;
	assign pair2_high_out_n = pwm_q[4] | ~fault_trip_input_n;
	assign pair2_low_out_n = pwm_q[5] | ~fault_trip_input_n;
	assign period_sync_pulse = sync_q & fault_trip_input_n;

endmodule // tpwm_timing

// >>> tpwm_timing_chk.sv
`timescale 1ns/1ns
module tpwm_timing_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fault_trip_input_n,
	input wire logic pair0_high_out_n,
	input wire logic pair0_low_out_n,
	input wire logic pair1_high_out_n,
	input wire logic pair1_low_out_n,
	input wire logic pair2_high_out_n,
	input wire logic pair2_low_out_n,
	input wire logic period_sync_pulse,
	input wire logic sync_irq,
	input wire logic trip_irq
);
	import tpwm_pkg::*;
	logic [5:0] outs;
	logic seen;
	assign outs = {pair0_low_out_n, pair0_high_out_n, pair1_low_out_n, pair1_high_out_n,
		pair2_low_out_n, pair2_high_out_n};
	// Remembers that a period sync pulse was seen at least once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seen <= 1'b0;
		else if (period_sync_pulse)
			seen <= 1'b1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	a_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready) else $error("pready late");
	a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_irq_sync: assert property (sync_irq == period_sync_pulse) else $error("irq apart");
	a_sync_pulse: assert property (period_sync_pulse |=> !period_sync_pulse) else $error("sync wide");
	a_trip_off: assert property (!fault_trip_input_n |-> outs == TPWM_OUT_OFF) else $error("trip on");
	a_trip_nosync: assert property (!fault_trip_input_n |-> !period_sync_pulse) else $error("tsync");
	a_trip_irq: assert property ($fell(fault_trip_input_n) |-> ##[1:4] trip_irq) else $error("no tirq");
	a_quiet_start: assert property (!seen |-> outs == TPWM_OUT_OFF) else $error("early out");
	a_no_overlap: assert property ((outs[5] | outs[4]) && (outs[3] | outs[2]) && (outs[1] | outs[0]))
		else $error("both on");
endmodule // tpwm_timing_chk
bind tpwm_timing tpwm_timing_chk tpwm_timing_chk_inst (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .fault_trip_input_n, .pair0_high_out_n, .pair0_low_out_n, .pair1_high_out_n,
	.pair1_low_out_n, .pair2_high_out_n, .pair2_low_out_n, .period_sync_pulse, .sync_irq, .trip_irq);

// >>> tpwm_drive_model.sv
`timescale 1ns/1ns
module tpwm_drive_model (
	input wire logic pclk,
	input wire logic [5:0] gate_n,
	input wire logic sync,
	output logic [5:0][15:0] low_sum,
	output logic [15:0] win_len
);
	logic [5:0][15:0] run = '0;
	logic [5:0][15:0] last = '0;
	logic [15:0] len = '0;
	// On-time of each switch over the last two sync windows
	always @(posedge pclk)
	begin
		len <= sync ? 16'h0001 : len + 16'h0001;
		if (sync)
			win_len <= len;
		for (int i = 0; i < 6; i++)
		begin
			run[i] <= sync ? 16'(!gate_n[i]) : run[i] + 16'(!gate_n[i]);
			if (sync)
			begin
				last[i] <= run[i];
				low_sum[i] <= run[i] + last[i];
			end
		end
	end
endmodule // tpwm_drive_model

// >>> test_tpwm_timing.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module test_tpwm_timing;
	import tpwm_pkg::*;
	localparam int P = 20;
	localparam int D = 2;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trip_n = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, s;
	logic pready, pslverr, er, p0h, p0l, p1h, p1l, p2h, p2l, sync, sirq, tirq;
	logic [5:0][15:0] low_sum;
	logic [15:0] win_len;
	int n_fail = 0, checks = 0, cyc = 0, n_sync = 0, n_trip = 0, t0;
	int dt[3] = '{8, 10, 12};
	tpwm_timing tpwm_timing_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_trip_input_n(trip_n), .pair0_high_out_n(p0h),
		.pair0_low_out_n(p0l), .pair1_high_out_n(p1h), .pair1_low_out_n(p1l),
		.pair2_high_out_n(p2h), .pair2_low_out_n(p2l), .period_sync_pulse(sync),
		.sync_irq(sirq), .trip_irq(tirq));
	tpwm_drive_model tpwm_drive_model_inst (.pclk(pclk), .gate_n({p0l, p0h, p1l, p1h, p2l, p2h}),
		.sync(sync), .low_sum(low_sum), .win_len(win_len));
	always #50 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		n_sync <= n_sync + int'(sync);
		n_trip <= n_trip + int'(tirq);
		if (cyc == 3000)
		begin
			n_fail++;
			finish_test();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wsync();
		int w;
		w = 0;
		do
		begin
			@(posedge pclk);
			w++;
		end while (sync !== 1'b1 && w < 200);
		`CHK("sync_seen", 1'b1, sync)
	endtask
	// Expected low cycles of pin i over two windows, after crossover and disable
	function automatic logic [15:0] ex(int i, int k, logic [8:0] oec);
		int p, j, h;
		p = 2 - i / 2;
		j = oec[8 - p] ? i ^ 1 : i;
		h = (j % 2 == 0) ? dt[p] - D : P - dt[p] - D;
		return oec[i] ? 16'h0000 : 16'(k * h);
	endfunction
	task automatic meas(input int k, input logic [8:0] oec, input int len);
		repeat (4) wsync();
		#1;
		for (int j = 0; j < 6; j++)
			`CHK("on_time", ex(j, k, oec), low_sum[j])
		`CHK("window", 16'(len), win_len)
		$display("test measure done");
	endtask
	task automatic cfg();
		apb(1'b1, TPWM_OFF_PERIOD, 32'(P));
		t0 = cyc;
		for (int p = 0; p < 3; p++)
			apb(1'b1, TPWM_OFF_DUTY0 + 8'(4 * p), 32'(dt[p]));
		wsync();
	endtask
	task automatic finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, TPWM_OFF_CONTROL, 32'h0);
		`CHK("control_rst", 32'h0, rd)
		apb(1'b0, TPWM_OFF_OEC, 32'h0);
		`CHK("oec_rst", 32'h0, rd)
		apb(1'b1, TPWM_OFF_DEAD, 32'hFFFFFFFF);
		apb(1'b0, TPWM_OFF_DEAD, 32'h0);
		`CHK("dead_max", 32'h3FF, rd)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped_err", 1'b1, er)
		`CHK("unmapped_data", 32'h0, rd)
		$display("test registers done");
		apb(1'b1, TPWM_OFF_DEAD, 32'(D));
		cfg();
		`CHK("first_sync", 1'b1, (cyc - t0) inside {[29:34]})
		meas(4, 9'h000, 2 * P);
		apb(1'b1, TPWM_OFF_OEC, 32'h112);
		meas(4, 9'h112, 2 * P);
		apb(1'b1, TPWM_OFF_OEC, 32'h0);
		apb(1'b1, TPWM_OFF_CONTROL, 32'h4);
		meas(2, 9'h000, P);
		wsync();
		apb(1'b0, TPWM_OFF_STATUS, 32'h0);
		s = rd;
		wsync();
		apb(1'b0, TPWM_OFF_STATUS, 32'h0);
		`CHK("half_flag", 1'b1, s[0] ^ rd[0])
		trip_n <= 1'b0;
		t0 = n_sync;
		repeat (100) @(posedge pclk);
		`CHK("trip_irq", 1, n_trip)
		`CHK("sync_stop", t0, n_sync)
		trip_n <= 1'b1;
		$display("test trip done");
		repeat (4) @(posedge pclk);
		cfg();
		`CHK("resume_sync", 1'b1, (cyc - t0) inside {[19:24]})
		meas(2, 9'h000, P);
		finish_test();
	end
endmodule // test_tpwm_timing
